// [rtl/fwpcf_core.sv]
// Functional notes
// - Complement, block granularity: 000 all protected, 111 none, else top/bottom 64KB<<(n-1) free for code n.
// - Complement, sector granularity: codes give 4/8/16/32KB free at top or bottom.
// - Erase or program touching any protected byte is discarded, array untouched.
// - Individual lock bits govern protection only when scheme select is one.
// - All individual lock bits are one after reset.
// - Chip select falling edge starts decoding a fresh instruction.
// - First eight bits after selection form the opcode.
// - Data sampled on link clock rising edge, most significant bit first.
// - Opcode followed by address, data or dummy bytes per opcode.
// - Chip select rising edge marks instruction completion.
// - Reads end cleanly on any bit count.
// - Write, program or erase ending off a byte boundary is ignored.
// - While busy only status register one read is accepted.
// - Scheme select zero: protection from complement, granularity, top/bottom and size code.
`timescale 1ns/100ps
`default_nettype none
module fwpcf_core
(
   // clock and reset
   input  wire  logic                      clk_in,
   input  wire  logic                      nrst_in,
   // serial link
   input  wire  logic                      spi_cs_n_in,
   input  wire  logic                      spi_clk_in,
   input  wire  logic                      serial_data_in_in,
   // protection fields
   input  wire  logic                      protect_scheme_select_in,
   input  wire  logic                      protect_complement_in,
   input  wire  logic                      granularity_select_in,
   input  wire  logic                      top_bottom_select_in,
   input  wire  logic [2:0]                protect_size_code_in,
   // array status
   input  wire  logic                      busy_in,
   // command results
   output logic                            op_go_out,
   output logic                            op_protect_reject_out,
   output logic                            op_ignore_out,
   output logic                            read_end_out,
   output logic [7:0]                      cmd_opcode_out,
   output logic [fwpcf_pkg::ADDR_W-1:0]    cmd_addr_out,
   output logic [fwpcf_pkg::NUM_LOCK-1:0]  lock_bits_out
);
   import fwpcf_pkg::*;

   logic [SYNC_STAGES-1:0] cs_sync_reg;
   logic [SYNC_STAGES-1:0] clk_sync_reg;
   logic [SYNC_STAGES-1:0] di_sync_reg;
   logic                   cs_last_reg;
   logic                   clk_last_reg;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   clk_rise;
   logic [5:0]             bit_cnt_reg;
   logic [2:0]             bit_mod_reg;
   logic [7:0]             shift_reg;
   logic [7:0]             opcode_reg;
   logic [ADDR_W-1:0]      addr_reg;
   logic [NUM_LOCK-1:0]    lock_reg;
   fwpcf_act_t             act_next;
   logic [SPAN_W-1:0]      rng_lo;
   logic [SPAN_W-1:0]      rng_hi;
   logic                   is_array_op;
   logic                   allowed;

   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_RD_SR1)
             || (op == OP_RD_SR2) || (op == OP_RD_SR3) || (op == OP_RD_SFDP)
             || (op == OP_RD_SECR) || (op == OP_RD_LOCK) || (op == OP_RD_JEDEC)
             || (op == OP_RD_MFID) || (op == OP_RD_DEVID) || (op == OP_RD_UID);
   endfunction

   function automatic logic needs_addr(input logic [7:0] op);
      needs_addr = (op == OP_PAGE_PROG) || (op == OP_ERASE_4K) || (op == OP_ERASE_32K)
                || (op == OP_ERASE_64K) || (op == OP_LOCK_ONE) || (op == OP_UNLK_ONE);
   endfunction

   // lock bit that covers a byte address
   function automatic logic [6:0] lock_index(input logic [ADDR_W-1:0] a);
      if (a[21:16] == 6'h00)
         lock_index = {3'h0, a[15:12]};
      else if (a[21:16] == LAST_BLOCK)
         lock_index = TOP_SEC_IDX + {3'h0, a[15:12]};
      else
         lock_index = MID_BLK_IDX + {1'b0, a[21:16]} - 7'h01;
   endfunction

   function automatic logic [SPAN_W-1:0] lock_lo(input int i);
      if (i < 16)
         lock_lo = BOT_SEC_BASE + SPAN_W'(i * 4096);
      else if (i < 32)
         lock_lo = TOP_SEC_BASE + SPAN_W'((i - 16) * 4096);
      else
         lock_lo = SPAN_W'((i - 31) * 65536);
   endfunction

   // size of the status-field region, zero when empty
   function automatic logic [SPAN_W-1:0] region_size(input logic sec, input logic [2:0] code);
      if (code == 3'h0)
         region_size = '0;
      else if (code == 3'h7)
         region_size = ARRAY_BYTES;
      else if (!sec)
         region_size = BLOCK_BYTES << (code - 3'h1);
      else if (code[2])
         region_size = HALF_BLOCK;
      else
         region_size = SECTOR_BYTES << (code[1:0] - 2'h1);
   endfunction

   // link sampling
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cs_sync_reg  <= '1;
         clk_sync_reg <= '0;
         di_sync_reg  <= '0;
         cs_last_reg  <= 1'b1;
         clk_last_reg <= 1'b0;
      end
      else
      begin
         cs_sync_reg  <= {cs_sync_reg[SYNC_STAGES-2:0], spi_cs_n_in};
         clk_sync_reg <= {clk_sync_reg[SYNC_STAGES-2:0], spi_clk_in};
         di_sync_reg  <= {di_sync_reg[SYNC_STAGES-2:0], serial_data_in_in};
         cs_last_reg  <= cs_sync_reg[SYNC_STAGES-1];
         clk_last_reg <= clk_sync_reg[SYNC_STAGES-1];
      end
   end

   assign cs_fall  = cs_last_reg && !cs_sync_reg[SYNC_STAGES-1];
   assign cs_rise  = !cs_last_reg && cs_sync_reg[SYNC_STAGES-1];
   assign clk_rise = !clk_last_reg && clk_sync_reg[SYNC_STAGES-1]
                  && !cs_sync_reg[SYNC_STAGES-1];

   // bit counting and shifting
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         bit_cnt_reg <= '0;
         bit_mod_reg <= '0;
         shift_reg   <= '0;
         opcode_reg  <= '0;
         addr_reg    <= '0;
      end
      else if (cs_fall)
      begin
         bit_cnt_reg <= '0;
         bit_mod_reg <= '0;
         opcode_reg  <= '0;
         addr_reg    <= '0;
      end
      else if (clk_rise)
      begin
         shift_reg   <= {shift_reg[6:0], di_sync_reg[SYNC_STAGES-1]};
         bit_mod_reg <= bit_mod_reg + 3'h1;
         if (bit_cnt_reg != BITS_SAT)
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         if (bit_cnt_reg == OPCODE_BITS - 6'h01)
            opcode_reg <= {shift_reg[6:0], di_sync_reg[SYNC_STAGES-1]};
         else if (bit_cnt_reg >= OPCODE_BITS && bit_cnt_reg < ADDR_END)
            addr_reg <= {addr_reg[ADDR_W-2:0], di_sync_reg[SYNC_STAGES-1]};
      end
   end

   // range touched by the command, aligned to its erase or page size
   always_comb
   begin
      is_array_op = 1'b1;
      rng_lo      = {1'b0, addr_reg};
      rng_hi      = {1'b0, addr_reg};
      case (opcode_reg)
         OP_PAGE_PROG:
         begin
            rng_lo = {1'b0, addr_reg[21:8], 8'h00};
            rng_hi = {1'b0, addr_reg[21:8], 8'hFF};
         end
         OP_ERASE_4K:
         begin
            rng_lo = {1'b0, addr_reg[21:12], 12'h000};
            rng_hi = {1'b0, addr_reg[21:12], 12'hFFF};
         end
         OP_ERASE_32K:
         begin
            rng_lo = {1'b0, addr_reg[21:15], 15'h0000};
            rng_hi = {1'b0, addr_reg[21:15], 15'h7FFF};
         end
         OP_ERASE_64K:
         begin
            rng_lo = {1'b0, addr_reg[21:16], 16'h0000};
            rng_hi = {1'b0, addr_reg[21:16], 16'hFFFF};
         end
         OP_CHIP_ER_A, OP_CHIP_ER_B:
         begin
            rng_lo = '0;
            rng_hi = ARRAY_BYTES - 23'h000001;
         end
         default:
            is_array_op = 1'b0;
      endcase
   end

   // protection check over the whole range
   always_comb
   begin
      logic [SPAN_W-1:0] size;
      logic [SPAN_W-1:0] reg_lo;
      logic [SPAN_W-1:0] reg_hi;
      logic [SPAN_W-1:0] llo;
      size    = region_size(granularity_select_in, protect_size_code_in);
      reg_lo  = top_bottom_select_in ? '0 : ARRAY_BYTES - size;
      reg_hi  = top_bottom_select_in ? size - 23'h000001 : ARRAY_BYTES - 23'h000001;
      llo     = '0;
      allowed = 1'b1;
      if (protect_scheme_select_in)
      begin
         for (int i = 0; i < NUM_LOCK; i++)
         begin
            llo = lock_lo(i);
            if (lock_reg[i] && !(rng_hi < llo
                || rng_lo > llo + ((i < 32) ? SECTOR_BYTES : BLOCK_BYTES) - 23'h000001))
               allowed = 1'b0;
         end
      end
      else if (protect_complement_in)
         allowed = (size != '0) && (rng_lo >= reg_lo) && (rng_hi <= reg_hi);
      else
         allowed = (size == '0) || (rng_hi < reg_lo) || (rng_lo > reg_hi);
   end

   // decision at deselect
   always_comb
   begin
      act_next = FWPCF_ACT_NONE;
      if (cs_rise && bit_cnt_reg >= OPCODE_BITS)
      begin
         if (busy_in && opcode_reg != OP_RD_SR1)
            act_next = FWPCF_ACT_IGN;
         else if (is_read(opcode_reg))
            act_next = FWPCF_ACT_NONE;
         else if (bit_mod_reg != 3'h0)
            act_next = FWPCF_ACT_IGN;
         else if (needs_addr(opcode_reg) && bit_cnt_reg < ADDR_END)
            act_next = FWPCF_ACT_IGN;
         else if (is_array_op && !allowed)
            act_next = FWPCF_ACT_PROT;
         else
            act_next = FWPCF_ACT_GO;
      end
   end

   // result outputs
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         op_go_out             <= 1'b0;
         op_protect_reject_out <= 1'b0;
         op_ignore_out         <= 1'b0;
         read_end_out          <= 1'b0;
         cmd_opcode_out        <= '0;
         cmd_addr_out          <= '0;
      end
      else
      begin
         op_go_out             <= (act_next == FWPCF_ACT_GO);
         op_protect_reject_out <= (act_next == FWPCF_ACT_PROT);
         op_ignore_out         <= (act_next == FWPCF_ACT_IGN);
         read_end_out          <= cs_rise && bit_cnt_reg >= OPCODE_BITS
                               && is_read(opcode_reg)
                               && !(busy_in && opcode_reg != OP_RD_SR1);
         if (cs_rise && bit_cnt_reg >= OPCODE_BITS)
         begin
            cmd_opcode_out <= opcode_reg;
            cmd_addr_out   <= addr_reg;
         end
      end
   end

   // individual lock bits
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         lock_reg <= '1;
      else if (act_next == FWPCF_ACT_GO)
         case (opcode_reg)
            OP_LOCK_ONE: lock_reg[lock_index(addr_reg)] <= 1'b1;
            OP_UNLK_ONE: lock_reg[lock_index(addr_reg)] <= 1'b0;
            OP_LOCK_ALL: lock_reg <= '1;
            OP_UNLK_ALL: lock_reg <= '0;
            default:     lock_reg <= lock_reg;
         endcase
   end
   assign lock_bits_out = lock_reg;
endmodule
`default_nettype wire

// [rtl/fwpcf_pkg.sv]
package fwpcf_pkg;
   // array geometry
   localparam int          ADDR_W       = 22;
   localparam int          SPAN_W       = 23;
   localparam logic [22:0] ARRAY_BYTES  = 23'h400000;
   localparam logic [22:0] SECTOR_BYTES = 23'h001000;
   localparam logic [22:0] HALF_BLOCK   = 23'h008000;
   localparam logic [22:0] BLOCK_BYTES  = 23'h010000;
   localparam logic [22:0] BOT_SEC_BASE = 23'h000000;
   localparam logic [22:0] TOP_SEC_BASE = 23'h3F0000;
   // lock bits: 16 sectors of block 0, 16 of block 63, then blocks 1..62
   localparam int          NUM_LOCK     = 94;
   localparam logic [6:0]  TOP_SEC_IDX  = 7'h10;
   localparam logic [6:0]  MID_BLK_IDX  = 7'h20;
   localparam logic [5:0]  LAST_BLOCK   = 6'h3F;
   // framing
   localparam int          SYNC_STAGES  = 2;
   localparam logic [5:0]  OPCODE_BITS  = 6'h08;
   localparam logic [5:0]  ADDR_END     = 6'h20;
   localparam logic [5:0]  BITS_SAT     = 6'h3F;
   // opcodes
   localparam logic [7:0] OP_READ      = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_RD_SR1    = 8'h05;
   localparam logic [7:0] OP_RD_SR2    = 8'h35;
   localparam logic [7:0] OP_RD_SR3    = 8'h15;
   localparam logic [7:0] OP_RD_SFDP   = 8'h5A;
   localparam logic [7:0] OP_RD_SECR   = 8'h48;
   localparam logic [7:0] OP_RD_LOCK   = 8'h3D;
   localparam logic [7:0] OP_RD_JEDEC  = 8'h9F;
   localparam logic [7:0] OP_RD_MFID   = 8'h90;
   localparam logic [7:0] OP_RD_DEVID  = 8'hAB;
   localparam logic [7:0] OP_RD_UID    = 8'h4B;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_ERASE_4K  = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_CHIP_ER_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_ER_B = 8'h60;
   localparam logic [7:0] OP_LOCK_ONE  = 8'h36;
   localparam logic [7:0] OP_UNLK_ONE  = 8'h39;
   localparam logic [7:0] OP_LOCK_ALL  = 8'h7E;
   localparam logic [7:0] OP_UNLK_ALL  = 8'h98;
   typedef enum logic [1:0] {FWPCF_ACT_NONE, FWPCF_ACT_GO,
                             FWPCF_ACT_PROT, FWPCF_ACT_IGN} fwpcf_act_t;
endpackage

// [test/fwpcf_core_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module fwpcf_core_checker
   import fwpcf_pkg::*;
(
   // clock, reset, link
   input wire logic                            clk_in,
   input wire logic                            nrst_in,
   input wire logic                            spi_cs_n_in,
   // protection fields and array status
   input wire logic                            protect_scheme_select_in,
   input wire logic                            protect_complement_in,
   input wire logic [2:0]                      protect_size_code_in,
   input wire logic                            busy_in,
   // results
   input wire logic                            op_go_out,
   input wire logic                            op_protect_reject_out,
   input wire logic                            op_ignore_out,
   input wire logic                            read_end_out,
   input wire logic [7:0]                      cmd_opcode_out,
   input wire logic [fwpcf_pkg::NUM_LOCK-1:0]  lock_bits_out
);
   logic pulse;
   logic array_op;
   logic open_map;
   assign pulse = op_go_out | op_protect_reject_out | op_ignore_out | read_end_out;
   assign array_op = cmd_opcode_out inside {OP_PAGE_PROG, OP_ERASE_4K, OP_ERASE_32K,
                                            OP_ERASE_64K, OP_CHIP_ER_A, OP_CHIP_ER_B};
   assign open_map = !protect_scheme_select_in && protect_complement_in;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence selected_s;
      !spi_cs_n_in [*3];
   endsequence
   sequence quiet_after_s;
      ##1 !pulse [*3];
   endsequence
   chk_single_result: assert property ($onehot0({op_go_out, op_ignore_out,
      op_protect_reject_out, read_end_out})) else $error("two results at once");
   chk_pulse_width: assert property (pulse |-> quiet_after_s)
      else $error("result pulse too long");
   chk_after_deselect: assert property (pulse |-> $past(spi_cs_n_in) && $past(spi_cs_n_in, 2))
      else $error("result while selected");
   chk_quiet_selected: assert property (selected_s |-> !pulse)
      else $error("result during a frame");
   chk_busy_blocks: assert property ((op_go_out || op_protect_reject_out) |-> !$past(busy_in))
      else $error("command taken while busy");
   chk_none_open: assert property (op_protect_reject_out |-> !(open_map && protect_size_code_in == 3'h7))
      else $error("reject with nothing protected");
   chk_all_closed: assert property ((op_go_out && array_op && open_map) |-> protect_size_code_in != 3'h0)
      else $error("array op with all protected");
   chk_lock_init: assert property ($rose(nrst_in) |-> &lock_bits_out)
      else $error("locks not set after reset");
   chk_lock_cause: assert property ($changed(lock_bits_out) |-> op_go_out)
      else $error("locks changed without command");
   chk_opcode_cause: assert property ($changed(cmd_opcode_out) |-> pulse)
      else $error("opcode changed without result");
endmodule
bind fwpcf_core fwpcf_core_checker u_checker (.*);
`default_nettype wire

// [test/fwpcf_spi_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fwpcf_spi_host
(
   // launch reference
   input  wire logic clk_in,
   // link pins
   output var  logic spi_cs_n_out,
   output var  logic spi_clk_out,
   output var  logic spi_data_out
);
   initial
   begin
      spi_cs_n_out = 1'h1;
      spi_clk_out  = 1'h0;
      spi_data_out = 1'h1;
   end
   // n bits of frame, msb first; link clock idles low outside frames
   task automatic xfer(input logic [63:0] frame, input int n);
      @(posedge clk_in);
      #1 spi_cs_n_out = 1'h0;
      for (int i = 0; i < n; i++)
      begin
         spi_data_out = frame[63 - i];
         #80 spi_clk_out = 1'h1;
         #80 spi_clk_out = 1'h0;
      end
      #80 spi_cs_n_out = 1'h1;
      spi_data_out = ~spi_data_out;
   endtask
endmodule
`default_nettype wire

// [test/test_flash_write_protect_and_cmd_framing.sv]
`timescale 1ns/100ps
`default_nettype none
module test_flash_write_protect_and_cmd_framing;
   import fwpcf_pkg::*;
   localparam logic [3:0] GO = 4'h1;
   localparam logic [3:0] PR = 4'h2;
   localparam logic [3:0] IG = 4'h4;
   localparam logic [3:0] RD = 4'h8;
   localparam logic [3:0] NO = 4'h0;
   logic                clk_in;
   logic                nrst_in;
   logic                spi_cs_n_in;
   logic                spi_clk_in;
   logic                serial_data_in_in;
   logic                protect_scheme_select_in;
   logic                protect_complement_in;
   logic                granularity_select_in;
   logic                top_bottom_select_in;
   logic [2:0]          protect_size_code_in;
   logic                busy_in;
   logic                op_go_out;
   logic                op_protect_reject_out;
   logic                op_ignore_out;
   logic                read_end_out;
   logic [7:0]          cmd_opcode_out;
   logic [ADDR_W-1:0]   cmd_addr_out;
   logic [NUM_LOCK-1:0] lock_bits_out;
   logic [23:0]         unit;
   logic [23:0]         grain;
   logic [7:0]          op;
   int                  err_total;
   int                  checks_done;
   fwpcf_core DUT (.*);
   fwpcf_spi_host host (.clk_in(clk_in), .spi_cs_n_out(spi_cs_n_in), .spi_clk_out(spi_clk_in),
                        .spi_data_out(serial_data_in_in));
   initial
   begin
      clk_in = 1'h0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // fields in order scheme, complement, granularity, top_bottom, size code
   task automatic setp(input logic [6:0] f);
      @(posedge clk_in);
      #1 {protect_scheme_select_in, protect_complement_in, granularity_select_in,
          top_bottom_select_in, protect_size_code_in} = f;
   endtask
   // one frame, then every result pulse in the answer window is collected
   task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int n, input logic [3:0] exp);
      logic [3:0] seen;
      seen = NO;
      host.xfer({opc, a, 32'hA5C35A3C}, n);
      repeat (10)
      begin
         @(posedge clk_in);
         #1 seen = seen | {read_end_out, op_ignore_out, op_protect_reject_out, op_go_out};
      end
      check("result", seen, exp);
      if (n >= 8) check("opcode", cmd_opcode_out, opc);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #1ms;
      err_total++;
      report_and_stop();
   end
   initial
   begin
      err_total = 0;
      checks_done = 0;
      nrst_in = 1'h0;
      busy_in = 1'h0;
      {protect_scheme_select_in, protect_complement_in, granularity_select_in} = 3'h0;
      {top_bottom_select_in, protect_size_code_in} = 4'h0;
      repeat (20) @(posedge clk_in);
      #1 nrst_in = 1'h1;
      check("locks", lock_bits_out, {NUM_LOCK{1'h1}});
      repeat (3) @(posedge clk_in);
      for (int t = 0; t < 2; t++)
         for (int s = 0; s < 2; s++)
            for (int c = 1; c < 7 - s; c++)
            begin
               setp({2'h1, s[0], t[0], c[2:0]});
               grain = s ? 24'h001000 : 24'h010000;
               unit = grain << (s && c > 4 ? 3 : c - 1);
               op = s ? OP_ERASE_4K : OP_ERASE_64K;
               cmd(op, t ? unit - grain : 24'h400000 - unit, 32, GO);
               cmd(op, t ? unit : 24'h400000 - unit - grain, 32, PR);
            end
      $display("test map done");
      setp(7'h34);
      cmd(OP_ERASE_32K, 24'h3F8000, 32, GO);
      cmd(OP_PAGE_PROG, 24'h3F7F00, 40, PR);
      cmd(OP_CHIP_ER_A, 24'h000000, 8, PR);
      setp(7'h05);
      cmd(OP_ERASE_64K, 24'h2F0000, 32, GO);
      cmd(OP_ERASE_64K, 24'h300000, 32, PR);
      setp(7'h20);
      cmd(OP_ERASE_4K, 24'h3FF000, 32, PR);
      setp(7'h27);
      cmd(OP_CHIP_ER_B, 24'h000000, 8, GO);
      $display("test ranges done");
      cmd(OP_ERASE_4K, 24'h3FF000, 33, IG);
      cmd(OP_CHIP_ER_A, 24'h000000, 12, IG);
      cmd(OP_READ, 24'h123456, 35, RD);
      check("addr", cmd_addr_out, 22'h123456);
      cmd(OP_PAGE_PROG, 24'h000000, 5, NO);
      $display("test framing done");
      @(posedge clk_in);
      #1 busy_in = 1'h1;
      cmd(OP_ERASE_4K, 24'h000000, 32, IG);
      cmd(OP_RD_SR1, 24'h000000, 16, RD);
      cmd(OP_RD_SR2, 24'h000000, 16, IG);
      @(posedge clk_in);
      #1 busy_in = 1'h0;
      $display("test busy done");
      setp(7'h67);
      cmd(OP_ERASE_4K, 24'h000000, 32, PR);
      cmd(OP_UNLK_ALL, 24'h000000, 8, GO);
      check("locks", lock_bits_out, 128'h0);
      cmd(OP_ERASE_4K, 24'h000000, 32, GO);
      cmd(OP_LOCK_ONE, 24'h3F0000, 32, GO);
      check("locks", lock_bits_out, 128'h1 << TOP_SEC_IDX);
      cmd(OP_ERASE_4K, 24'h3F0000, 32, PR);
      setp(7'h27);
      cmd(OP_ERASE_4K, 24'h3F0000, 32, GO);
      cmd(OP_LOCK_ALL, 24'h000000, 8, GO);
      check("locks", lock_bits_out, {NUM_LOCK{1'h1}});
      cmd(OP_UNLK_ONE, 24'h050000, 32, GO);
      check("locks", lock_bits_out, {NUM_LOCK{1'h1}} & ~(128'h1 << (MID_BLK_IDX + 7'h04)));
      setp(7'h67);
      cmd(OP_ERASE_64K, 24'h050000, 32, GO);
      cmd(OP_ERASE_64K, 24'h060000, 32, PR);
      nrst_in = 1'h0;
      repeat (2) @(posedge clk_in);
      #1 nrst_in = 1'h1;
      check("locks", lock_bits_out, {NUM_LOCK{1'h1}});
      $display("test locks done");
      report_and_stop();
   end
endmodule
`default_nettype wire
